// >>> bench/reset_partner.sv
/*
  Model of the reset sources around the controller: pin with pull-up,
  supply monitor, low-voltage detector and watchdog.
  Assumes the bench calls its tasks; lines change just after a clock edge.
*/
`timescale 1ns/1ps
module reset_partner (
  input wire logic clk_i,
  input wire logic pin_oe_n_i,
  input wire logic pin_val_i,
  output logic power_up_o,
  output logic pin_o,
  output logic low_volt_o,
  output logic wdog_o
);
  logic [3:0] src_q;

  initial src_q = 4'h0;

  // Pull-up: the wire is low while either party pulls it
  assign pin_o = ((!pin_oe_n_i && !pin_val_i) || src_q[0]) ? 1'b0 : 1'b1;
  // Source lines, each held long enough to pass two synchroniser flops
  assign power_up_o = src_q[1];
  assign low_volt_o = src_q[2];
  assign wdog_o = src_q[3];

  task drive(input int s, input logic v);
    @(posedge clk_i);
    src_q[s] <= v;
  endtask

  task pulse(input int s);
    drive(s, 1'b1);
    repeat (4) @(posedge clk_i);
    src_q[s] <= 1'b0;
  endtask
endmodule

// >>> bench/system_reset_control_bench.sv
/*
  Bench for the system reset controller: Wishbone register tests, each
  reset source, interrupt, oscillator type and power-up with pin held.
  Assumes the partner model and the bound checker.
*/
`timescale 1ns/1ps
module system_reset_control_bench;
  localparam logic [63:0] SERIAL = 64'h1122334455667788; // Arbitrary value
  localparam logic [31:0] STAT = reset_ctrl_pkg::ADDR_RESET_CAUSE_STATUS;
  localparam logic [31:0] IEN = reset_ctrl_pkg::ADDR_IRQ_ENABLE;
  localparam logic [31:0] ICLR = reset_ctrl_pkg::ADDR_IRQ_CLEAR;
  localparam logic [31:0] OPT = reset_ctrl_pkg::ADDR_CODE_OPTION_WORD;
  localparam logic [31:0] CTRL =
    reset_ctrl_pkg::ADDR_APP_INTERRUPT_RESET_CONTROL;
  logic clk_i, rst_i, req, we;
  logic [3:0] sel;
  logic [31:0] adr, dat, rd;
  logic [15:0] lv [4];
  wire logic pu, pin, low_v, wd, pin_o, oe_n, ack, sr, irq;
  wire logic [31:0] dat_o;
  wire logic [15:0] sec;
  int err_count, checks, n0, n1;
  int bits [4];

  reset_partner P (.clk_i, .pin_oe_n_i(oe_n), .pin_val_i(pin_o),
    .power_up_o(pu), .pin_o(pin), .low_volt_o(low_v), .wdog_o(wd));

  system_reset_control #(.RC_WARMUP(8), .CRYSTAL_WARMUP(16),
    .DIE_SERIAL(SERIAL)) DUT (.clk_i, .rst_i, .power_up_i(pu),
    .reset_pin_i(pin), .reset_pin_o(pin_o), .reset_pin_oe_n_o(oe_n),
    .low_voltage_detect_i(low_v), .watchdog_timer_i(wd), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(sel),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_ack_o(ack), .system_reset_o(sr),
    .core_fetch_o(), .core_fetch_addr_o(), .core_load_sp_o(),
    .core_load_pc_o(), .security_level_o(sec), .irq_o(irq));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req <= 1'b1;
    sel <= 4'hf;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = dat_o;
    req <= 1'b0;
    sel <= 4'h0;
    we <= 1'b0;
    if (n >= 50)
    begin
      err_count++;
      results();
    end
  endtask

  // Wait for reset to start, then count cycles until the core runs
  task boot(output int n);
    int k;
    k = 0;
    while (sr !== 1'b1 && k < 10)
    begin
      @(posedge clk_i);
      k++;
    end
    n = 0;
    while (sr !== 1'b0 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    if (k >= 10 || n >= 300)
    begin
      err_count++;
      results();
    end
  endtask

  initial
  begin
    rst_i = 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = 32'h0;
    sel = 4'h0;
    dat = 32'h0;
    lv = '{reset_ctrl_pkg::SECURITY_LEVEL_1, reset_ctrl_pkg::SECURITY_LEVEL_2,
      reset_ctrl_pkg::SECURITY_LEVEL_3, reset_ctrl_pkg::SECURITY_LEVEL_0};
    bits = '{0, 2, 3, 4};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    boot(n0);
    wb(1'b0, CTRL, 32'h0);
    chk("reset control", 32'h0, rd);
    wb(1'b0, OPT, 32'h0);
    chk("option", 32'hffffffff, rd);
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, OPT, {lv[i], 16'h0});
      wb(1'b0, OPT, 32'h0);
      chk("option", {lv[i], 16'hffff}, rd);
      chk("level", {16'h0, lv[i]}, {16'h0, sec});
    end
    wb(1'b1, reset_ctrl_pkg::ADDR_SERIAL_NUMBER_LOW, 32'h0);
    wb(1'b0, reset_ctrl_pkg::ADDR_SERIAL_NUMBER_LOW, 32'h0);
    chk("serial low", SERIAL[31:0], rd);
    wb(1'b0, reset_ctrl_pkg::ADDR_SERIAL_NUMBER_HIGH, 32'h0);
    chk("serial high", SERIAL[63:32], rd);
    wb(1'b0, 32'h40000010, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test registers done");
    wb(1'b1, CTRL, 32'h05fb0004);
    wb(1'b1, CTRL, 32'h05fa0000);
    repeat (6) @(posedge clk_i);
    chk("no reset", 32'h0, {31'h0, sr});
    $display("test key done");
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, ICLR, 32'h1f);
      if (i == 3) wb(1'b1, CTRL, 32'h05fa0004);
      else P.pulse(bits[i] == 0 ? 0 : bits[i]);
      boot(n0);
      wb(1'b0, STAT, 32'h0);
      chk("cause", 32'h1 << bits[i], rd);
    end
    $display("test sources done");
    // Last recorded cause is the software request
    wb(1'b1, IEN, 32'h1 << reset_ctrl_pkg::CAUSE_SOFTWARE);
    chk("irq on", 32'h1, {31'h0, irq});
    wb(1'b1, IEN, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wb(1'b1, IEN, 32'h1 << reset_ctrl_pkg::CAUSE_SOFTWARE);
    wb(1'b1, ICLR, 32'h1 << reset_ctrl_pkg::CAUSE_SOFTWARE);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    wb(1'b1, 32'h4000000c, 32'h3);
    P.pulse(3);
    boot(n1);
    chk("crystal longer", 32'h1, {31'h0, n1 >= n0 + 8});
    $display("test oscillator done");
    P.drive(0, 1'b1);
    P.drive(1, 1'b1);
    repeat (4) @(posedge clk_i);
    P.drive(1, 1'b0);
    repeat (20) @(posedge clk_i);
    chk("pin wait", 32'h1, {31'h0, sr});
    P.drive(0, 1'b0);
    boot(n0);
    wb(1'b0, STAT, 32'h0);
    chk("power cause", 32'h2, rd);
    $display("test power-up done");
    results();
  end
endmodule

// >>> bench/system_reset_control_props.sv
/*
  Checker for the system reset controller: bus answers, pin hold, boot
  fetch order and source response.
  Assumes it is bound to the top module; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module system_reset_control_props #(
  parameter int RC_WARMUP = 8
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic low_voltage_detect_i,
  input wire logic watchdog_timer_i,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_n_o,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic system_reset_o,
  input wire logic core_fetch_o,
  input wire logic [31:0] core_fetch_addr_o,
  input wire logic core_load_sp_o,
  input wire logic core_load_pc_o,
  input wire logic [15:0] security_level_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic ctrl_wr;
  logic key_ok;
  int low_q;

  // Decoded reset-control accesses at the acknowledging edge
  assign ctrl_wr = wb_ack_o && wb_we_i && wb_sel_i == 4'hf && wb_dat_i[2]
    && wb_adr_i == reset_ctrl_pkg::ADDR_APP_INTERRUPT_RESET_CONTROL;
  assign key_ok = wb_dat_i[31:16] == reset_ctrl_pkg::REGISTER_WRITE_KEY;

  // Cycles the pin has been driven; warm-up too long for a repetition
  always_ff @(posedge clk_i)
    if (rst_i || reset_pin_oe_n_o) low_q <= 0;
    else low_q <= low_q + 1;

  sequence sp_fetch_s;
    core_load_sp_o && core_fetch_o &&
    core_fetch_addr_o == reset_ctrl_pkg::STACK_POINTER_VECTOR;
  endsequence
  sequence pc_fetch_s;
    core_load_pc_o && core_fetch_o &&
    core_fetch_addr_o == reset_ctrl_pkg::RESET_VECTOR;
  endsequence

  ack_answer_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_single_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  key_reject_a:
    assert property (ctrl_wr && !key_ok && !system_reset_o |->
      !system_reset_o [*4]) else $error("keyless write acted");
  soft_reset_a:
    assert property (ctrl_wr && key_ok |-> ##[1:4] system_reset_o)
    else $error("software reset missing");
  ctrl_read_a:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i ==
      reset_ctrl_pkg::ADDR_APP_INTERRUPT_RESET_CONTROL |-> wb_dat_o == 0)
    else $error("reset control read not zero");
  option_read_a:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i ==
      reset_ctrl_pkg::ADDR_CODE_OPTION_WORD |->
      wb_dat_o == {security_level_o, 16'hffff}) else $error("option read");
  source_reset_a:
    assert property ($rose(watchdog_timer_i || low_voltage_detect_i) |->
      ##[1:6] system_reset_o) else $error("source ignored");
  pin_hold_a:
    assert property (!reset_pin_oe_n_o |-> system_reset_o && !reset_pin_o)
    else $error("pin driven outside reset");
  warm_length_a:
    assert property (core_load_sp_o |-> $rose(reset_pin_oe_n_o) &&
      low_q >= RC_WARMUP) else $error("warm-up short");
  boot_order_a:
    assert property (core_load_sp_o |-> sp_fetch_s ##1 pc_fetch_s ##1
      !system_reset_o) else $error("boot fetch order");
endmodule

bind system_reset_control system_reset_control_props #(
  .RC_WARMUP(RC_WARMUP)
) props_i (.clk_i, .rst_i, .low_voltage_detect_i, .watchdog_timer_i,
  .reset_pin_o, .reset_pin_oe_n_o, .wb_adr_i, .wb_dat_i, .wb_dat_o,
  .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .system_reset_o,
  .core_fetch_o, .core_fetch_addr_o, .core_load_sp_o, .core_load_pc_o,
  .security_level_o);

// >>> rtl/reset_ctrl_pkg.sv
/*
  Package for the system reset controller: register byte addresses, field
  positions, key and option encodings, reset values and warm-up counts.
  Assumes a 50 MHz system clock and a classic Wishbone slave with 32-bit data.
*/
package reset_ctrl_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_APP_INTERRUPT_RESET_CONTROL = 32'he000ed0c;
  localparam logic [31:0] ADDR_CODE_OPTION_WORD = 32'h1fff2000;
  localparam logic [31:0] ADDR_SERIAL_NUMBER_LOW = 32'h1fff2c08;
  localparam logic [31:0] ADDR_SERIAL_NUMBER_HIGH = 32'h1fff2c0c;
  localparam logic [31:0] ADDR_RESET_CAUSE_STATUS = 32'h40000000;
  localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h40000004;
  localparam logic [31:0] ADDR_IRQ_CLEAR = 32'h40000008;
  localparam logic [31:0] ADDR_RESET_CONFIG = 32'h4000000c;

  // Reset-control register fields
  localparam int KEY_HI = 31;
  localparam int KEY_LO = 16;
  localparam logic [15:0] REGISTER_WRITE_KEY = 16'h05fa;
  localparam int BYTE_ORDER_BIT = 15;
  localparam int SOFTWARE_RESET_REQUEST_BIT = 2;
  localparam int DEBUG_CLEAR_ACTIVE_BIT = 1;
  localparam logic BYTE_ORDER_LITTLE = 1'b0;

  // Code option word
  localparam logic [15:0] SECURITY_LEVEL_0 = 16'hffff;
  localparam logic [15:0] SECURITY_LEVEL_1 = 16'h5a5a;
  localparam logic [15:0] SECURITY_LEVEL_2 = 16'ha5a5;
  localparam logic [15:0] SECURITY_LEVEL_3 = 16'h55aa;
  localparam logic [15:0] OPTION_LOW_HALF = 16'hffff;

  // Reset cause bit positions
  localparam int CAUSE_PIN = 0;
  localparam int CAUSE_POWER_UP = 1;
  localparam int CAUSE_LOW_VOLTAGE = 2;
  localparam int CAUSE_WATCHDOG = 3;
  localparam int CAUSE_SOFTWARE = 4;
  localparam int NUM_CAUSES = 5;

  // Reset configuration bits
  localparam int CFG_PIN_ENABLE_BIT = 0;
  localparam int CFG_CRYSTAL_BIT = 1;
  localparam logic [1:0] RESET_CONFIG_RESET = 2'h1;

  // Core boot vectors
  localparam logic [31:0] STACK_POINTER_VECTOR = 32'h00000000;
  localparam logic [31:0] RESET_VECTOR = 32'h00000004;

  // Warm-up times and the cycle counts derived from them
  localparam int CLOCK_HZ = 50000000;
  localparam int RC_WARMUP_US = 32;
  localparam int CRYSTAL_WARMUP_US = 4000;
  localparam int RC_WARMUP_CYCLES = (RC_WARMUP_US * (CLOCK_HZ / 1000000));
  localparam int CRYSTAL_WARMUP_CYCLES =
    (CRYSTAL_WARMUP_US * (CLOCK_HZ / 1000000));
  localparam int WARMUP_W = 18;

  // Sequencer states
  typedef enum logic [2:0]
  {
    ST_HOLD = 3'b000,
    ST_PIN_WAIT = 3'b001,
    ST_WARMUP = 3'b010,
    ST_FETCH_SP = 3'b011,
    ST_FETCH_PC = 3'b100,
    ST_RUN = 3'b101
  } seq_state_e;

endpackage

// >>> rtl/system_reset_control.sv
/*
  System reset controller: merges five reset sources, records the cause,
  drives the open-drain reset pin low in hold and warm-up, counts
  oscillator warm-up, then hands the core its boot vector addresses.
  Assumes one 50 MHz clock clk_i, a power-on pulse from the supply monitor,
  and a classic Wishbone master for register access.
*/
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps

// Overview of operation
// RQ1 - Writes need key 0x05FA, else discarded
// RQ2 - Bit 2 requests system reset, reads zero
// RQ3 - Software writes zero to debug bit 1
// RQ4 - Bit 15 reads little-endian zero, others zero
// RQ5 - Option word upper half selects security
// RQ6 - Read-only 64-bit per-die serial number
// RQ7 - Five sources each cause a system reset
// RQ8 - Distinct cause flag for latest reset; flags here accumulate until cleared or until power-up
// RQ9 - Reset pin held low whole delay phase; pin is released in the pin wait
// RQ10 - Stack pointer loaded from address zero
// RQ11 - Program counter loaded from address four
// RQ12 - Delay includes oscillator warm-up, type dependent
// RQ13 - Power-up waits for released reset pin
// RQ14 - Watchdog reset reinitialises, warms, restarts
// RQ15 - Sources synchronised; reset held through warm-up
// RQ16 - Cause flags survive; power-up clears them
module system_reset_control #(
  parameter int RC_WARMUP = reset_ctrl_pkg::RC_WARMUP_CYCLES,
  parameter int CRYSTAL_WARMUP = reset_ctrl_pkg::CRYSTAL_WARMUP_CYCLES,
  parameter logic [63:0] DIE_SERIAL = 64'h0123456789abcdef // Arbitrary
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_up_i,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_n_o,
  input wire logic low_voltage_detect_i,
  input wire logic watchdog_timer_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic system_reset_o,
  output logic core_fetch_o,
  output logic [31:0] core_fetch_addr_o,
  output logic core_load_sp_o,
  output logic core_load_pc_o,
  output logic [15:0] security_level_o,
  output logic irq_o
);

  localparam int W = reset_ctrl_pkg::WARMUP_W;

  logic [1:0] pin_sync_q;
  logic [1:0] por_sync_q;
  logic [1:0] lowv_sync_q;
  logic [1:0] wdog_sync_q;
  logic pin_low;
  logic por_now;
  logic sw_req_q;
  logic [reset_ctrl_pkg::NUM_CAUSES-1:0] src_now;
  logic any_src;
  reset_ctrl_pkg::seq_state_e state_q;
  logic [W-1:0] warm_cnt_q;
  logic [W-1:0] warm_len;
  logic [reset_ctrl_pkg::NUM_CAUSES-1:0] cause_q;
  logic [reset_ctrl_pkg::NUM_CAUSES-1:0] irq_en_q;
  logic [1:0] cfg_q;
  logic [15:0] option_q;
  logic wb_req;
  logic wb_wr;
  logic key_ok;
  logic [31:0] rd_data;

  // Two-flop synchronisers for every pin-level source
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_sync_q <= 2'h0; // Pin wait must see a real high, not a stale one
      por_sync_q <= 2'h0;
      lowv_sync_q <= 2'h0;
      wdog_sync_q <= 2'h0;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[0], reset_pin_i}; // RQ15
      por_sync_q <= {por_sync_q[0], power_up_i};
      lowv_sync_q <= {lowv_sync_q[0], low_voltage_detect_i};
      wdog_sync_q <= {wdog_sync_q[0], watchdog_timer_i};
    end
  end

  // Pin only counts as a source when its reset function is enabled
  assign pin_low = ~pin_sync_q[1] & cfg_q[reset_ctrl_pkg::CFG_PIN_ENABLE_BIT];
  assign por_now = por_sync_q[1];

  // Source vector, one bit per cause
  always_comb
  begin
    src_now = '0;
    src_now[reset_ctrl_pkg::CAUSE_PIN] = pin_low &
      (state_q == reset_ctrl_pkg::ST_RUN); // RQ7
    src_now[reset_ctrl_pkg::CAUSE_POWER_UP] = por_now;
    src_now[reset_ctrl_pkg::CAUSE_LOW_VOLTAGE] = lowv_sync_q[1];
    src_now[reset_ctrl_pkg::CAUSE_WATCHDOG] = wdog_sync_q[1];
    src_now[reset_ctrl_pkg::CAUSE_SOFTWARE] = sw_req_q;
  end
  // Pin counts only in run, so our own drive never reads back as a cause
  assign any_src = |src_now;

  // Warm-up length depends on oscillator type
  assign warm_len = cfg_q[reset_ctrl_pkg::CFG_CRYSTAL_BIT] ?
                    W'(CRYSTAL_WARMUP - 1) : W'(RC_WARMUP - 1); // RQ12

  // Reset sequencer: hold, optional pin wait, warm-up, vector fetch, run
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= reset_ctrl_pkg::ST_HOLD;
      warm_cnt_q <= '0;
    end
    else if (any_src)
    begin
      state_q <= reset_ctrl_pkg::ST_HOLD; // RQ7
      warm_cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        reset_ctrl_pkg::ST_HOLD:
        begin
          state_q <= reset_ctrl_pkg::ST_PIN_WAIT;
        end
        reset_ctrl_pkg::ST_PIN_WAIT:
        begin
          // Wait until the outside world releases the pin high
          if (pin_sync_q[1] || !cfg_q[reset_ctrl_pkg::CFG_PIN_ENABLE_BIT])
          begin
            state_q <= reset_ctrl_pkg::ST_WARMUP; // RQ13
          end
        end
        reset_ctrl_pkg::ST_WARMUP:
        begin
          if (warm_cnt_q >= warm_len)
          begin
            state_q <= reset_ctrl_pkg::ST_FETCH_SP; // RQ15
          end
          else
          begin
            warm_cnt_q <= warm_cnt_q + 1'b1;
          end
        end
        reset_ctrl_pkg::ST_FETCH_SP:
        begin
          state_q <= reset_ctrl_pkg::ST_FETCH_PC; // RQ14
        end
        reset_ctrl_pkg::ST_FETCH_PC:
        begin
          state_q <= reset_ctrl_pkg::ST_RUN;
        end
        default:
        begin
          state_q <= reset_ctrl_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Pin driven low in hold and warm-up; let go in the pin wait, else our
  // own pull would read back as an outside low and the wait never ends
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_n_o = ~(state_q == reset_ctrl_pkg::ST_HOLD ||
                              state_q == reset_ctrl_pkg::ST_WARMUP); // RQ9
  assign system_reset_o = (state_q != reset_ctrl_pkg::ST_RUN);

  // Boot vector fetch strobes towards the core
  always_comb
  begin
    core_fetch_o = 1'b0;
    core_load_sp_o = 1'b0;
    core_load_pc_o = 1'b0;
    core_fetch_addr_o = reset_ctrl_pkg::STACK_POINTER_VECTOR;
    if (state_q == reset_ctrl_pkg::ST_FETCH_SP)
    begin
      core_fetch_o = 1'b1;
      core_load_sp_o = 1'b1; // RQ10
    end
    else if (state_q == reset_ctrl_pkg::ST_FETCH_PC)
    begin
      core_fetch_o = 1'b1;
      core_load_pc_o = 1'b1;
      core_fetch_addr_o = reset_ctrl_pkg::RESET_VECTOR; // RQ11
    end
  end

  // Bus decode; one-cycle ack, dropped the cycle after
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign key_ok = (wb_dat_i[reset_ctrl_pkg::KEY_HI:reset_ctrl_pkg::KEY_LO]
                   == reset_ctrl_pkg::REGISTER_WRITE_KEY) &
                  (&wb_sel_i[3:2]); // RQ1

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req;
    end
  end

  // Keyed software reset request; stays set until the sequencer takes it.
  // Bit 1 is left to software to keep zero and is simply ignored here.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sw_req_q <= 1'b0;
    end
    else if (wb_wr && key_ok && wb_sel_i[0] &&
             wb_adr_i == reset_ctrl_pkg::ADDR_APP_INTERRUPT_RESET_CONTROL &&
             wb_dat_i[reset_ctrl_pkg::SOFTWARE_RESET_REQUEST_BIT])
    begin
      sw_req_q <= 1'b1; // RQ2 RQ3
    end
    else if (state_q != reset_ctrl_pkg::ST_RUN)
    begin
      sw_req_q <= 1'b0;
    end
  end

  // Cause flags: power-up wipes the rest; other sources accumulate
  // so a hit arriving with a clear is kept
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cause_q <= '0;
    end
    else if (por_now)
    begin
      cause_q <= 5'h1 << reset_ctrl_pkg::CAUSE_POWER_UP; // RQ16
    end
    else if (wb_wr && wb_adr_i == reset_ctrl_pkg::ADDR_IRQ_CLEAR &&
             wb_sel_i[0])
    begin
      cause_q <= (cause_q & ~wb_dat_i[4:0]) | src_now; // RQ8
    end
    else
    begin
      cause_q <= cause_q | src_now; // RQ8
    end
  end

  // Software writable settings survive all but the bus reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_en_q <= '0;
      cfg_q <= reset_ctrl_pkg::RESET_CONFIG_RESET;
      option_q <= reset_ctrl_pkg::SECURITY_LEVEL_0;
    end
    else if (wb_wr && wb_sel_i[0])
    begin
      if (wb_adr_i == reset_ctrl_pkg::ADDR_IRQ_ENABLE)
      begin
        irq_en_q <= wb_dat_i[4:0];
      end
      else if (wb_adr_i == reset_ctrl_pkg::ADDR_RESET_CONFIG)
      begin
        cfg_q <= wb_dat_i[1:0];
      end
      else if (wb_adr_i == reset_ctrl_pkg::ADDR_CODE_OPTION_WORD &&
               (&wb_sel_i[3:2]))
      begin
        option_q <= wb_dat_i[31:16]; // RQ5
      end
    end
  end

  assign security_level_o = option_q;
  assign irq_o = |(cause_q & irq_en_q);

  // Read mux; key field reads zero, unmapped addresses read zero
  always_comb
  begin
    rd_data = 32'h0;
    if (wb_adr_i == reset_ctrl_pkg::ADDR_APP_INTERRUPT_RESET_CONTROL)
    begin
      rd_data[reset_ctrl_pkg::BYTE_ORDER_BIT] =
        reset_ctrl_pkg::BYTE_ORDER_LITTLE; // RQ4
    end
    else if (wb_adr_i == reset_ctrl_pkg::ADDR_CODE_OPTION_WORD)
    begin
      rd_data = {option_q, reset_ctrl_pkg::OPTION_LOW_HALF}; // RQ5
    end
    else if (wb_adr_i == reset_ctrl_pkg::ADDR_SERIAL_NUMBER_LOW)
    begin
      rd_data = DIE_SERIAL[31:0]; // RQ6
    end
    else if (wb_adr_i == reset_ctrl_pkg::ADDR_SERIAL_NUMBER_HIGH)
    begin
      rd_data = DIE_SERIAL[63:32]; // RQ6
    end
    else if (wb_adr_i == reset_ctrl_pkg::ADDR_RESET_CAUSE_STATUS)
    begin
      rd_data = {27'h0, cause_q};
    end
    else if (wb_adr_i == reset_ctrl_pkg::ADDR_IRQ_ENABLE)
    begin
      rd_data = {27'h0, irq_en_q};
    end
    else if (wb_adr_i == reset_ctrl_pkg::ADDR_RESET_CONFIG)
    begin
      rd_data = {30'h0, cfg_q};
    end
  end

  // Read data registered alongside ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0;
    end
    else if (wb_req && !wb_we_i)
    begin
      wb_dat_o <= rd_data;
    end
  end

endmodule
